/* core/fbw_seq.sv */
// Flash block write sequencer: AXI4-Lite registers, key unlock, latches, halt.
// Assumes the array accepts one-cycle erase/program pulses and reads combinationally.
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fbw_seq
  import fbw_pkg::*;
#(
  parameter int HALT_CYC = FBW_HALT_CYC           // Programming halt length
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_awaddr_i,
  input  wire logic                 s_awvalid_i,
  output logic                      s_awready_o,
  input  wire logic [31:0]          s_wdata_i,
  input  wire logic [3:0]           s_wstrb_i,
  input  wire logic                 s_wvalid_i,
  output logic                      s_wready_o,
  output logic [1:0]                s_bresp_o,
  output logic                      s_bvalid_o,
  input  wire logic                 s_bready_i,
  input  wire logic [7:0]           s_araddr_i,
  input  wire logic                 s_arvalid_i,
  output logic                      s_arready_o,
  output logic [31:0]               s_rdata_o,
  output logic [1:0]                s_rresp_o,
  output logic                      s_rvalid_o,
  input  wire logic                 s_rready_i,
  // Configuration and array side
  input  wire logic [1:0]           write_protect_segments_i,
  input  wire logic [14:0]          wp_limit_i,
  input  wire logic [13:0]          arr_rdata_i,
  output logic                      arr_rd_o,
  output fbw_arr_req_s              arr_req_o,
  output logic [FBW_LATCHES*14-1:0] arr_wdata_o,
  output logic                      cpu_halt_o,
  output logic                      write_complete_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Config-space address readable
  function automatic logic cfg_rd_ok(input logic [14:0] a);
    cfg_rd_ok = (a <= FBW_UID_HI) || (a >= FBW_DEVID && a <= FBW_CFG_HI);
  endfunction

  // Segment unprotected: protect code 2'b11 means off, else below limit is locked
  // Limitation: judged on the word address, so a limit inside a block splits it
  function automatic logic seg_open(input logic [1:0] wp, input logic [14:0] a,
                                    input logic [14:0] lim);
    seg_open = (wp == 2'h3) || (a >= lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]  ctrl_reg, ctrl_next;        // Memory control register
  logic [14:0] addr_reg, addr_next;        // Word address
  logic [13:0] data_reg, data_next;        // Word data
  logic [1:0]  key_reg, key_next;          // Key progress: 0 none, 1 got 55h, 2 got AAh
  logic        done_reg, done_next;        // Write-complete flag
  logic [13:0] latch_reg [FBW_LATCHES];    // Write latches
  logic [13:0] latch_next [FBW_LATCHES];
  fbw_state_e  st_reg, st_next;            // Sequencer state
  logic [31:0] cnt_reg, cnt_next;          // Halt/setup counter
  fbw_arr_req_s req_reg, req_next;         // Array pulse
  logic        aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [7:0]  awa_reg, awa_next;          // Captured write address
  logic [31:0] wd_reg, wd_next;            // Captured write data
  logic [3:0]  ws_reg, ws_next;            // Captured strobes
  logic [31:0] rd_reg, rd_next;            // Read data
  logic [1:0]  rr_reg, rr_next, br_reg, br_next;

  logic do_wr, do_rd;                      // Register access this cycle
  assign do_wr = aw_reg && w_reg && !b_reg;
  assign do_rd = s_arvalid_i && s_arready_o;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus, registers and sequencer
  always_comb begin
    ctrl_next = ctrl_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    key_next  = key_reg;
    done_next = done_reg;
    latch_next = latch_reg;
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    req_next  = '0;
    aw_next = aw_reg;
    w_next  = w_reg;
    b_next  = b_reg;
    r_next  = r_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    ws_next = ws_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    br_next = br_reg;
    arr_rd_o = 1'b0;
    // Channel captures, in either order
    if (s_awvalid_i && !aw_reg) begin
      aw_next  = 1'b1;
      awa_next = s_awaddr_i;
    end
    if (s_wvalid_i && !w_reg) begin
      w_next  = 1'b1;
      wd_next = s_wdata_i;
      ws_next = s_wstrb_i;
    end
    if (b_reg && s_bready_i) begin
      b_next = 1'b0;
    end
    if (r_reg && s_rready_i) begin
      r_next = 1'b0;
    end
    // Register write, lane 0 only carries data
    if (do_wr) begin
      aw_next = 1'b0;
      w_next  = 1'b0;
      b_next  = 1'b1;
      br_next = 2'b00;
      // Any write but the next key breaks the unlock sequence
      key_next = 2'h0;
      if (ws_reg[0]) begin
        unique case (awa_reg)
          FBW_CTRL_OFS: begin
            ctrl_next[FBW_B_PGM]        = wd_reg[FBW_B_PGM];
            ctrl_next[FBW_B_CFG_SEL]    = wd_reg[FBW_B_CFG_SEL];
            ctrl_next[FBW_B_LATCH_ONLY] = wd_reg[FBW_B_LATCH_ONLY];
            ctrl_next[FBW_B_FREE]       = wd_reg[FBW_B_FREE];
            ctrl_next[FBW_B_ARM]        = wd_reg[FBW_B_ARM];
            if (!wd_reg[FBW_B_ERR]) ctrl_next[FBW_B_ERR] = 1'b0;
            // Start bit only sets when armed and keyed
            if (wd_reg[FBW_B_WR] && st_reg == FBW_IDLE) begin
              key_next = 2'h0;
              if (ctrl_reg[FBW_B_ARM] && key_reg == 2'h2) begin
                ctrl_next[FBW_B_WR] = 1'b1;
                st_next  = FBW_SETUP;
                cnt_next = 32'(FBW_SETUP_CYC);
              end
            end
            // Read: data ready next cycle; bad config address clears data
            if (wd_reg[FBW_B_RD]) begin
              arr_rd_o = !wd_reg[FBW_B_CFG_SEL] || cfg_rd_ok(addr_reg);
              data_next = arr_rd_o ? arr_rdata_i : '0;
            end
          end
          FBW_KEY_OFS: begin
            if (wd_reg[7:0] == FBW_KEY1) key_next = 2'h1;
            else if (wd_reg[7:0] == FBW_KEY2 && key_reg == 2'h1) key_next = 2'h2;
            else key_next = 2'h0;
          end
          FBW_ADDRL_OFS: addr_next[7:0]   = wd_reg[7:0];
          FBW_ADDRH_OFS: addr_next[14:8]  = wd_reg[6:0];
          FBW_DATAL_OFS: data_next[7:0]   = wd_reg[7:0];
          FBW_DATAH_OFS: data_next[13:8]  = wd_reg[5:0];
          FBW_STAT_OFS:  if (!wd_reg[0]) done_next = 1'b0;
          default: br_next = 2'b10;
        endcase
      end
    end
    // Register read
    if (do_rd) begin
      r_next  = 1'b1;
      rr_next = 2'b00;
      unique case (s_araddr_i)
        FBW_CTRL_OFS:  rd_next = {24'h0, ctrl_reg};
        FBW_KEY_OFS:   rd_next = 32'h0;
        FBW_ADDRL_OFS: rd_next = {24'h0, addr_reg[7:0]};
        FBW_ADDRH_OFS: rd_next = {25'h0, addr_reg[14:8]};
        FBW_DATAL_OFS: rd_next = {24'h0, data_reg[7:0]};
        FBW_DATAH_OFS: rd_next = {26'h0, data_reg[13:8]};
        FBW_STAT_OFS:  rd_next = {30'h0, cpu_halt_o, done_reg};
        default: begin
          rd_next = 32'h0;
          rr_next = 2'b10;
        end
      endcase
    end
    // Sequencer
    unique case (st_reg)
      FBW_IDLE: ;
      FBW_SETUP: begin
        // Two setup cycles before acting
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h1) begin
          if (ctrl_reg[FBW_B_FREE] && !ctrl_reg[FBW_B_CFG_SEL]
              && seg_open(write_protect_segments_i, addr_reg, wp_limit_i)) begin
            req_next.erase = 1'b1;
            req_next.base  = addr_reg & ~{10'h0, FBW_ROW_MASK};
            st_next  = FBW_HALT;
            cnt_next = 32'(HALT_CYC);
          end else if (ctrl_reg[FBW_B_FREE]) begin
            ctrl_next[FBW_B_ERR] = 1'b1;
            st_next = FBW_RESUME;
          end else begin
            // Store word in latch slot of its block
            latch_next[addr_reg[2:0]] = data_reg;
            if (ctrl_reg[FBW_B_LATCH_ONLY]) begin
              st_next = FBW_RESUME;
            end else if (ctrl_reg[FBW_B_CFG_SEL] ? (addr_reg <= FBW_UID_HI)
                 : seg_open(write_protect_segments_i, addr_reg, wp_limit_i)) begin
              req_next.prog = 1'b1;
              req_next.base = addr_reg & ~{12'h0, FBW_BLK_MASK};
              st_next  = FBW_HALT;
              cnt_next = 32'(HALT_CYC);
            end else begin
              ctrl_next[FBW_B_ERR] = 1'b1;
              st_next = FBW_RESUME;
            end
          end
        end
      end
      FBW_HALT: begin
        // Only execution halts; this logic and the clock keep running
        cnt_next = cnt_reg - 32'h1;
        if (cnt_reg == 32'h1) begin
          st_next = FBW_RESUME;
          done_next = 1'b1;
          for (int i = 0; i < FBW_LATCHES; i++) latch_next[i] = FBW_ONES;
        end
      end
      FBW_RESUME: begin
        ctrl_next[FBW_B_WR] = 1'b0;
        st_next = FBW_IDLE;
      end
      default: st_next = FBW_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= 8'h00;
      addr_reg <= 15'h0000;
      data_reg <= 14'h0000;
      key_reg  <= 2'h0;
      done_reg <= 1'b0;
      for (int i = 0; i < FBW_LATCHES; i++) latch_reg[i] <= FBW_ONES;
      st_reg   <= FBW_IDLE;
      cnt_reg  <= 32'h0;
      req_reg  <= '0;
      aw_reg <= 1'b0;
      w_reg  <= 1'b0;
      b_reg  <= 1'b0;
      r_reg  <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      rd_reg <= 32'h0;
      rr_reg <= 2'h0;
      br_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      key_reg  <= key_next;
      done_reg <= done_next;
      latch_reg <= latch_next;
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      req_reg  <= req_next;
      aw_reg <= aw_next;
      w_reg  <= w_next;
      b_reg  <= b_next;
      r_reg  <= r_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      ws_reg <= ws_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
      br_reg <= br_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_awready_o = !aw_reg;
  assign s_wready_o  = !w_reg;
  assign s_bvalid_o  = b_reg;
  assign s_bresp_o   = br_reg;
  assign s_arready_o = !r_reg;
  assign s_rvalid_o  = r_reg;
  assign s_rdata_o   = rd_reg;
  assign s_rresp_o   = rr_reg;
  assign arr_req_o   = req_reg;
  assign cpu_halt_o  = (st_reg == FBW_SETUP) || (st_reg == FBW_HALT);
  assign write_complete_flag_o = done_reg;
  for (genvar g = 0; g < FBW_LATCHES; g++) begin : g_lat
    assign arr_wdata_o[g*14 +: 14] = latch_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_START_ARMED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg == FBW_IDLE && st_next == FBW_SETUP) |-> ctrl_reg[FBW_B_ARM])
    else $error("start without arm");
  AST_START_KEY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg == FBW_IDLE && st_next == FBW_SETUP) |-> key_reg == 2'h2)
    else $error("start without key");
  AST_KEY_USED: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(ctrl_reg[FBW_B_WR]) |-> key_reg == 2'h0)
    else $error("key not consumed");
  AST_SETUP_TWO: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(st_reg == FBW_SETUP) |-> (st_reg == FBW_SETUP) [*2] ##1 st_reg != FBW_SETUP)
    else $error("setup not two cycles");
  AST_LATCH_ONLY_NO_PROG: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_reg.prog |-> !ctrl_reg[FBW_B_LATCH_ONLY])
    else $error("program during latch-only");
  AST_LATCH_NO_HALT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg == FBW_SETUP && ctrl_reg[FBW_B_LATCH_ONLY]) |-> ##[1:2] st_reg == FBW_RESUME)
    else $error("latch load stalled");
  AST_PROG_ALIGN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_reg.prog |-> req_reg.base[2:0] == 3'h0)
    else $error("block misaligned");
  AST_ERASE_ALIGN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    req_reg.erase |-> req_reg.base[4:0] == 5'h0)
    else $error("row misaligned");
  AST_DONE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (st_reg == FBW_HALT && cnt_reg == 32'h1) |=> done_reg ##1 !ctrl_reg[FBW_B_WR])
    else $error("completion not flagged");
  COV_LATCH: cover property (@(posedge core_clk_i) req_reg.prog == 1'b0 && st_reg == FBW_RESUME);
  COV_PROG: cover property (@(posedge core_clk_i) req_reg.prog);
  COV_ERASE: cover property (@(posedge core_clk_i) req_reg.erase);
  // A refused config read must leave both data halves cleared
  AST_BAD_CFG_READ: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (do_wr && ws_reg[0] && awa_reg == FBW_CTRL_OFS && wd_reg[FBW_B_RD]
     && wd_reg[FBW_B_CFG_SEL] && !cfg_rd_ok(addr_reg)) |=> data_reg == 14'h0000)
    else $error("refused config read left data");
  // Execution is only released through the resume step
  AST_RESUME_AFTER_HALT: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $fell(cpu_halt_o) |-> st_reg == FBW_RESUME)
    else $error("execution released outside resume");
  // Refusals and config reads are the paths most easily left unexercised
  COV_REFUSED: cover property (@(posedge core_clk_i) $rose(ctrl_reg[FBW_B_ERR]));
  COV_CFG_READ: cover property (@(posedge core_clk_i) arr_rd_o && wd_reg[FBW_B_CFG_SEL]);

endmodule : fbw_seq
`default_nettype wire

/* common/fbw_pkg.sv */
// Constants, types and register layout for the flash block write sequencer.
// Assumes one 250 MHz core clock and an AXI4-Lite register port.
// Contract
// - No automatic erase when a write starts
// - Write only to segments left unprotected
// - Blocks of eight words, aligned base
// - One write never spans two blocks
// - Latch-only mode just loads the latch
// - Two setup cycles after start bit
// - First seven latch loads never stall
// - Halt execution about 2 ms while programming
// - Clocks keep running during the halt
// - Resume at third instruction after start
// - Config select targets config space
// - User IDs read-write; ID, config read-only
// - Bad config read clears data registers
// - Start bit needs the arm bit set
// - Keys and start must come in order
// - Row erase clears 32 aligned words
// - Completion clears start, sets done flag
`default_nettype none
package fbw_pkg;

  // Register byte offsets
  localparam logic [7:0] FBW_CTRL_OFS  = 8'h00;  // Memory control register
  localparam logic [7:0] FBW_KEY_OFS   = 8'h04;  // Unlock key port
  localparam logic [7:0] FBW_ADDRL_OFS = 8'h08;  // Word address low
  localparam logic [7:0] FBW_ADDRH_OFS = 8'h0c;  // Word address high
  localparam logic [7:0] FBW_DATAL_OFS = 8'h10;  // Word data low
  localparam logic [7:0] FBW_DATAH_OFS = 8'h14;  // Word data high
  localparam logic [7:0] FBW_STAT_OFS  = 8'h18;  // Status: done flag, halt

  // Control register bit positions
  localparam int FBW_B_RD         = 0;
  localparam int FBW_B_WR         = 1;
  localparam int FBW_B_ARM        = 2;
  localparam int FBW_B_ERR        = 3;
  localparam int FBW_B_FREE       = 4;
  localparam int FBW_B_LATCH_ONLY = 5;
  localparam int FBW_B_CFG_SEL    = 6;
  localparam int FBW_B_PGM        = 7;

  // Unlock keys
  localparam logic [7:0] FBW_KEY1 = 8'h55;
  localparam logic [7:0] FBW_KEY2 = 8'haa;

  // Geometry
  localparam int FBW_LATCHES = 8;
  localparam logic [2:0] FBW_BLK_MASK = 3'h7;
  localparam logic [4:0] FBW_ROW_MASK = 5'h1f;
  localparam logic [13:0] FBW_ONES    = 14'h3fff;
  localparam logic [1:0] FBW_SETUP_CYC = 2'h2;

  // Config space addresses (low byte, chosen by the config select bit)
  localparam logic [14:0] FBW_UID_LO  = 15'h0000;
  localparam logic [14:0] FBW_UID_HI  = 15'h0003;
  localparam logic [14:0] FBW_DEVID   = 15'h0006;
  localparam logic [14:0] FBW_CFG_LO  = 15'h0007;
  localparam logic [14:0] FBW_CFG_HI  = 15'h0008;

  // Halt time and its cycle count at 250 MHz
  localparam int FBW_HALT_US  = 2000;
  localparam int FBW_CLK_MHZ  = 250;
  localparam int FBW_HALT_CYC = FBW_HALT_US * FBW_CLK_MHZ;

  // Sequencer states
  typedef enum logic [2:0] {
    FBW_IDLE  = 3'b000,
    FBW_SETUP = 3'b001,
    FBW_HALT  = 3'b010,
    FBW_RESUME= 3'b011
  } fbw_state_e;

  // Request towards the flash array
  typedef struct packed {
    logic        prog;    // Program eight latched words
    logic        erase;   // Erase one 32-word row
    logic [14:0] base;    // Aligned word address
  } fbw_arr_req_s;

endpackage : fbw_pkg
`default_nettype wire

/* bench/fbw_arr_model.sv */
// Flash array model: a 512-word window of erased cells with a blank check.
// Assumes one-cycle erase/program pulses and a combinational read port.
`timescale 1ns/100ps
`default_nettype none
module fbw_arr_model
  import fbw_pkg::*;
#(
  parameter logic [13:0] RD_VAL = 14'h1a5c  // Arbitrary read pattern
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      arr_rd_i,
  input  wire fbw_arr_req_s              arr_req_i,
  input  wire logic [FBW_LATCHES*14-1:0] arr_wdata_i,
  output logic [13:0]                    arr_rdata_o,
  output int                             n_bad_o
);
  logic [13:0] mem [512];  // Cells start erased
  logic [13:0] noise;      // Stays at 1 every cycle (2 minus itself), so it never matches the read pattern
  initial begin
    foreach (mem[k]) mem[k] = FBW_ONES;
    noise = 14'h0001;
    n_bad_o = 0;
  end
  // Read data is only meaningful while a read is issued
  assign arr_rdata_o = arr_rd_i ? RD_VAL : noise;
  ////////////////////////////////////////////////////////////////////////////
  // Erase fills a row; program insists on erased targets
  always @(posedge core_clk_i) begin
    noise <= ~noise + 14'h0003;
    if (arr_req_i.erase === 1'b1)
      for (int k = 0; k < 32; k++) mem[{arr_req_i.base[8:5], k[4:0]}] <= FBW_ONES;
    if (arr_req_i.prog === 1'b1)
      for (int k = 0; k < 8; k++) begin
        if (mem[{arr_req_i.base[8:3], k[2:0]}] !== FBW_ONES) n_bad_o <= n_bad_o + 1;
        mem[{arr_req_i.base[8:3], k[2:0]}] <= arr_wdata_i[k*14 +: 14];
      end
  end
endmodule  // fbw_arr_model
`default_nettype wire

/* bench/flash_block_write_sequencer_bench.sv */
// Bench for the sequencer: AXI4-Lite master tasks, array model, monitors.
// Assumes a shortened halt count so a program cycle takes a few cycles.
`timescale 1ns/100ps
`default_nettype none
module flash_block_write_sequencer_bench;
  import fbw_pkg::*;
  localparam int HC = 20;                 // Shortened halt length
  localparam logic [13:0] RV = 14'h1a5c;  // Array read pattern
  logic clk, rst_n, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv, ard, halt, done;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdt;
  logic [1:0] brs, rrs, wps;
  logic [14:0] lim;
  logic [13:0] ardat;
  fbw_arr_req_s req, lreq;                // Live and last array request
  logic [111:0] wdat, lwd;                // Live and captured latches
  int n_mismatch, cmp_count, nreq, hrun, hlast, tick, nbad;
  logic [1:0] lbr;                        // Last write response
  fbw_seq #(.HALT_CYC(HC)) i_fbw_seq (.core_clk_i(clk), .rst_n_i(rst_n),
    .s_awaddr_i(awa), .s_awvalid_i(awv), .s_awready_o(awr), .s_wdata_i(wd),
    .s_wstrb_i(4'hf), .s_wvalid_i(wv), .s_wready_o(wrd), .s_bresp_o(brs),
    .s_bvalid_o(bv), .s_bready_i(bry), .s_araddr_i(ara), .s_arvalid_i(arv),
    .s_arready_o(arr), .s_rdata_o(rdt), .s_rresp_o(rrs), .s_rvalid_o(rv),
    .s_rready_i(rry), .write_protect_segments_i(wps), .wp_limit_i(lim),
    .arr_rdata_i(ardat), .arr_rd_o(ard), .arr_req_o(req), .arr_wdata_o(wdat),
    .cpu_halt_o(halt), .write_complete_flag_o(done));
  fbw_arr_model #(.RD_VAL(RV)) i_fbw_arr_model (.core_clk_i(clk), .arr_rd_i(ard),
    .arr_req_i(req), .arr_wdata_i(wdat), .arr_rdata_o(ardat), .n_bad_o(nbad));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Halt run length, request capture and the hang guard
  always @(posedge clk) begin
    tick <= tick + 1;
    if (halt === 1'b1) hrun <= hrun + 1;
    else if (hrun != 0) begin
      hlast <= hrun;
      hrun <= 0;
    end
    if (req.prog === 1'b1 || req.erase === 1'b1) begin
      nreq <= nreq + 1;
      lreq <= req;
      lwd <= wdat;
    end
    if (tick == 30000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Expected array bases: blocks of eight words, rows of 32 words
  function automatic logic [14:0] blk_base(input logic [14:0] a);
    return a & ~15'h0007;
  endfunction
  function automatic logic [14:0] row_base(input logic [14:0] a);
    return a & ~15'h001f;
  endfunction
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus master: both write channels offered together, each released when taken
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic ap, dp;
    ap = 1'b1;
    dp = 1'b1;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    while (ap || dp) begin
      @(posedge clk);
      if (ap && awr === 1'b1) begin ap = 1'b0; awv <= 1'b0; end
      if (dp && wrd === 1'b1) begin dp = 1'b0; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    lbr = brs;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    while (rv !== 1'b1) @(posedge clk);
    d = rdt;
    r = rrs;
    rry <= 1'b0;
    @(posedge clk);
  endtask
  // Address and data set up before each start
  task automatic ld(input logic [14:0] a, input logic [13:0] v);
    wreg(FBW_ADDRL_OFS, {24'h0, a[7:0]});
    wreg(FBW_ADDRH_OFS, {25'h0, a[14:8]});
    wreg(FBW_DATAL_OFS, {24'h0, v[7:0]});
    wreg(FBW_DATAH_OFS, {26'h0, v[13:8]});
  endtask
  // Mode with arm, then both keys, then the start bit
  task automatic go(input logic [7:0] c);
    wreg(FBW_CTRL_OFS, {24'h0, c});
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY1});
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY2});
    wreg(FBW_CTRL_OFS, {24'h0, c | 8'h02});
  endtask
  task automatic fin;
    logic [31:0] d;
    logic [1:0] r;
    do rreg(FBW_CTRL_OFS, d, r); while (d[FBW_B_WR] !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [13:0] v [8];
    logic [14:0] b, e;
    rst_n = 1'b0; awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; wps = 2'b11; lim = 15'h0000;
    n_mismatch = 0; cmp_count = 0; nreq = 0; hrun = 0; hlast = 0; tick = 0;
    void'($urandom(62));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rreg(FBW_CTRL_OFS, d, r); chk(d, 0); chk(r, 2'b00);
    rreg(FBW_STAT_OFS, d, r); chk(d, 0);
    chk(wdat, {FBW_LATCHES{FBW_ONES}});
    rreg(8'h1c, d, r); chk(r, 2'b10); chk(d, 0);
    wreg(8'h1c, 32'h0); chk(lbr, 2'b10);
    wreg(FBW_ADDRL_OFS, 32'h0); chk(lbr, 2'b00);
    $display("test reset done");
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY1});
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY2});
    wreg(FBW_CTRL_OFS, 32'h82);
    rreg(FBW_CTRL_OFS, d, r); chk(d[FBW_B_WR], 1'b0);
    wreg(FBW_CTRL_OFS, 32'h84);
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY2});
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY1});
    wreg(FBW_CTRL_OFS, 32'h86);
    rreg(FBW_CTRL_OFS, d, r); chk(d[FBW_B_WR], 1'b0);
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY1});
    wreg(FBW_KEY_OFS, {24'h0, FBW_KEY2});
    wreg(FBW_ADDRL_OFS, 32'h0);
    wreg(FBW_CTRL_OFS, 32'h86);
    rreg(FBW_CTRL_OFS, d, r); chk(d[FBW_B_WR], 1'b0);
    chk(nreq, 0); chk(hlast, 0);
    $display("test unlock done");
    b = 15'h0100 + 15'($urandom_range(0, 31) * 8);
    for (int i = 0; i < 7; i++) begin
      v[i] = (i == 3) ? FBW_ONES : 14'($urandom);
      ld(b + 15'(i), v[i]);
      go(8'ha4);
      fin();
      chk(hlast, FBW_SETUP_CYC);
      chk(nreq, 0);
      chk(wdat[i*14 +: 14], v[i]);
      if (i == 0) begin
        wreg(FBW_CTRL_OFS, 32'ha6);
        rreg(FBW_CTRL_OFS, d, r); chk(d[FBW_B_WR], 1'b0);
      end
    end
    v[7] = 14'($urandom);
    ld(b + 15'd7, v[7]);
    go(8'h84);
    rreg(FBW_STAT_OFS, d, r); chk(d[1], 1'b1);
    fin();
    chk(nreq, 1); chk(lreq.prog, 1'b1); chk(lreq.erase, 1'b0);
    chk(lreq.base, blk_base(b + 15'd7));
    for (int i = 0; i < 8; i++) chk(lwd[i*14 +: 14], v[i]);
    chk(hlast, FBW_SETUP_CYC + HC);
    chk(done, 1'b1);
    chk(wdat, {FBW_LATCHES{FBW_ONES}});
    wreg(FBW_STAT_OFS, 32'h0); chk(done, 1'b0);
    $display("test block write done");
    e = 15'h0200 + 15'($urandom_range(1, 31));
    ld(e, 14'h0);
    go(8'h94);
    fin();
    chk(nreq, 2); chk(lreq.erase, 1'b1); chk(lreq.base, row_base(e));
    $display("test erase done");
    wps <= 2'b01; lim <= 15'h7000;
    ld(15'h0100, 14'h0);
    go(8'h84);
    fin();
    chk(nreq, 2);
    ld(15'h7008, 14'h0);
    go(8'h84);
    fin();
    chk(nreq, 3); chk(lreq.base, 15'h7008);
    wps <= 2'b11;
    $display("test protection done");
    wreg(FBW_DATAL_OFS, 32'h5a);
    wreg(FBW_DATAH_OFS, 32'h15);
    ld(15'h0004, 14'h155a);
    wreg(FBW_CTRL_OFS, 32'h41);
    repeat (2) @(posedge clk);
    rreg(FBW_DATAL_OFS, d, r); chk(d, 0);
    rreg(FBW_DATAH_OFS, d, r); chk(d, 0);
    ld(FBW_UID_LO, 14'h0);
    wreg(FBW_CTRL_OFS, 32'h41);
    repeat (2) @(posedge clk);
    rreg(FBW_DATAL_OFS, d, r); chk(d[7:0], RV[7:0]);
    rreg(FBW_DATAH_OFS, d, r); chk(d[5:0], RV[13:8]);
    ld(FBW_DEVID, 14'h0);
    go(8'hc4);
    fin();
    rreg(FBW_CTRL_OFS, d, r); chk(d[FBW_B_ERR], 1'b1);
    chk(nreq, 3);
    chk(nbad, 0);
    $display("test config space done");
    complete_run();
  end
endmodule  // flash_block_write_sequencer_bench
`default_nettype wire
